// *** core/pcmd_top.sv ***
`default_nettype none
// Upper command bits of the configuration space and their effects.
module pcmd_top #(
  parameter pcmd_pkg::pcmd_step_t STEP_MODE  = pcmd_pkg::PCMD_STEP_OPTIONAL,
  parameter bit                   SNOOP_IMPL = 1'b1
) (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire pcmd_pkg::pcmd_cfg_req_t cfg,
  output logic [31:0]                cfg_rdata,
  output logic                       cfg_rvalid,
  input  wire pcmd_pkg::pcmd_bus_t   bus,
  input  wire logic                  par_in,
  output logic                       par_out,
  input  wire logic                  b2b_req,
  input  wire logic                  b2b_same_agent,
  output logic                       b2b_grant,
  input  wire logic                  palette_wr,
  output logic                       palette_claim,
  output logic                       palette_snoop,
  output logic                       serr_n_out,
  output logic                       serr_oe,
  output logic                       perr_n_out,
  output logic                       perr_oe,
  output logic                       detected_parity_error,
  output logic                       stepping_active,
  output logic                       mem_decode_en,
  output logic                       io_decode_en,
  output logic                       master_en,
  output logic                       cfg_only
);

  // Bits software may change; stepping and snoop follow the options.
  localparam logic [15:0] WMASK = pcmd_pkg::CMD_WMASK_BASE
    | ((STEP_MODE == pcmd_pkg::PCMD_STEP_OPTIONAL) ? pcmd_pkg::STEP_BIT
                                                   : 16'h0000)
    | (SNOOP_IMPL ? pcmd_pkg::SNOOP_BIT : 16'h0000);

  // Bits that read as one without being stored.
  localparam logic [15:0] FIXED1 =
    (STEP_MODE == pcmd_pkg::PCMD_STEP_ALWAYS) ? pcmd_pkg::STEP_BIT
                                              : 16'h0000;

  // Reset value: an optional stepper starts with stepping on.
  localparam logic [15:0] CMD_RST = pcmd_pkg::CMD_RESET
    | ((STEP_MODE == pcmd_pkg::PCMD_STEP_OPTIONAL) ? pcmd_pkg::STEP_BIT
                                                   : 16'h0000);

  logic [15:0] cmd;        // Stored command bits.
  logic [15:0] cmd_view;   // Command as software reads it.
  logic [15:0] next_cmd;   // Command after the current write.
  logic [31:0] wr_mask;    // Byte-lane mask of the current write.
  logic        par_gen;    // Generated parity from the helper.
  logic        addr_err;   // Address parity error pulse.
  logic        data_err;   // Data parity error pulse.
  logic        flag_clr;   // Software clears the status flag.
  logic        par_resp;   // Parity error response enable.
  logic        serr_en;    // System-error driver enable.
  logic        fast_b2b;   // Fast back-to-back enable.
  logic        snoop;      // Palette snoop enable.

  // Decoding of the command word is shared by reads and writes.
  function automatic logic cmd_hit(input logic [7:0] addr);
    cmd_hit = (addr[7:2] == pcmd_pkg::CMD_WORD_IDX);
  endfunction

  // Parity generation and checking live in a small helper.
  pcmd_parity u_parity (
    .core_clk (core_clk),
    .nrst     (nrst),
    .bus      (bus),
    .par_in   (par_in),
    .par_gen  (par_gen),
    .addr_err (addr_err),
    .data_err (data_err)
  );

  // Byte enables become a bit mask, one lane at a time.
  genvar g;
  generate
    for (g = 0; g < pcmd_pkg::LANES; g++) begin : g_lane
      assign wr_mask[g*pcmd_pkg::LANE_W +: pcmd_pkg::LANE_W] =
        {pcmd_pkg::LANE_W{cfg.be[g]}};
    end
  endgenerate

  // Writable bits take new data; read-only bits keep their value.
  // Reserved bits are simply stored, trusting software to write zero.
  always_comb begin
    next_cmd = cmd;
    if (cfg.wr && cmd_hit(cfg.addr)) begin
      next_cmd = (cmd & ~(WMASK & wr_mask[15:0]))
               | (cfg.wdata[15:0] & WMASK & wr_mask[15:0]);
    end
  end

  // The read view folds in the fixed stepping value.
  always_comb begin
    cmd_view = (cmd & WMASK) | FIXED1;
  end

  // Field aliases keep the effect logic readable.
  always_comb begin
    par_resp = cmd[pcmd_pkg::CMD_PAR_RESP];
    serr_en  = cmd[pcmd_pkg::CMD_SERR_EN];
    fast_b2b = cmd[pcmd_pkg::CMD_FAST_B2B];
    snoop = cmd[pcmd_pkg::CMD_SNOOP];
  end

  // Command register; parity response starts cleared.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmd <= CMD_RST;
    end else begin
      cmd <= next_cmd;
    end
  end

  // Status writes of one to bit 15 clear the flag.
  always_comb begin
    flag_clr = cfg.wr && cmd_hit(cfg.addr)
            && wr_mask[pcmd_pkg::STS_BASE + pcmd_pkg::STS_PAR_ERR]
            && cfg.wdata[pcmd_pkg::STS_BASE + pcmd_pkg::STS_PAR_ERR];
  end

  // The flag records every parity error whatever the enables say.
  // A new error in the clearing cycle wins, so no event is lost.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      detected_parity_error <= 1'b0;
    end else if (addr_err || data_err) begin
      detected_parity_error <= 1'b1;
    end else if (flag_clr) begin
      detected_parity_error <= 1'b0;
    end
  end

  // Configuration reads answer one clock later; unmapped words read zero.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_rdata  <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg.rd;
      if (cfg.rd && cmd_hit(cfg.addr)) begin
        cfg_rdata <= {detected_parity_error, 15'h0000, cmd_view};
      end else begin
        cfg_rdata <= 32'h0000_0000;
      end
    end
  end

  // PERR# is driven low for one clock after a data parity error, but
  // only with the response enabled; otherwise operation just continues.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      perr_oe    <= 1'b0;
      perr_n_out <= 1'b1;
    end else begin
      perr_oe    <= data_err && par_resp;
      perr_n_out <= !(data_err && par_resp);
    end
  end

  // SERR# is open drain: the driver only ever pulls low, and only
  // when both enables allow an address parity error to be reported.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      serr_oe    <= 1'b0;
      serr_n_out <= 1'b0;
    end else begin
      serr_oe    <= addr_err && serr_en && par_resp;
      serr_n_out <= 1'b0;
    end
  end

  // Parity goes out every clock; no enable can stop it.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      par_out <= 1'b0;
    end else begin
      par_out <= par_gen;
    end
  end

  // A fast back-to-back follow-on is allowed to the same agent always,
  // and to a different agent only when the enable is set.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      b2b_grant <= 1'b0;
    end else begin
      b2b_grant <= b2b_req && (b2b_same_agent || fast_b2b);
    end
  end

  // Palette writes are claimed normally, or left alone and snooped.
  // Claiming still needs the I/O decode to be on.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      palette_claim <= 1'b0;
      palette_snoop <= 1'b0;
    end else begin
      palette_claim <= palette_wr && !snoop
                    && cmd[pcmd_pkg::CMD_IOS];
      palette_snoop <= palette_wr && snoop;
    end
  end

  // Decode enables follow the command; an all-zero command leaves only
  // configuration accesses answered.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mem_decode_en   <= 1'b0;
      io_decode_en    <= 1'b0;
      master_en       <= 1'b0;
      cfg_only        <= 1'b1;
      stepping_active <= 1'b0;
    end else begin
      mem_decode_en   <= next_cmd[pcmd_pkg::CMD_MS];
      io_decode_en    <= next_cmd[pcmd_pkg::CMD_IOS];
      master_en       <= next_cmd[pcmd_pkg::CMD_BM];
      cfg_only        <= !(next_cmd[pcmd_pkg::CMD_MS]
                        || next_cmd[pcmd_pkg::CMD_IOS]
                        || next_cmd[pcmd_pkg::CMD_BM]);
      // An expression cannot be bit-selected, so the view is built per bit.
      stepping_active <= (next_cmd[pcmd_pkg::CMD_STEP]
                          & WMASK[pcmd_pkg::CMD_STEP])
                         | FIXED1[pcmd_pkg::CMD_STEP];
    end
  end

  // Helper: first clock after reset release.
  logic boot;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      boot <= 1'b1;
    end else begin
      boot <= 1'b0;
    end
  end

  // Checks on the effects of the command bits.
  sequence s_data_err_resp;
    data_err && par_resp;
  endsequence

  sequence s_addr_err_report;
    addr_err && serr_en && par_resp;
  endsequence

  // Back-to-back data errors legally keep PERR# low, so the end of the
  // pulse is checked on its own rather than as a fixed second step.
  a_perr_drive_on: assert property (
    @(posedge core_clk) disable iff (!nrst)
    s_data_err_resp |=> perr_oe && !perr_n_out)
    else $error("PERR# not pulsed after parity error");

  a_perr_pulse_end: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !(data_err && par_resp) |=> !perr_oe && perr_n_out)
    else $error("PERR# held without a new parity error");

  a_perr_quiet_off: assert property (
    @(posedge core_clk) disable iff (!nrst)
    data_err && !par_resp |=> !perr_oe && detected_parity_error)
    else $error("PERR# driven or flag missing with response off");

  a_serr_report_ok: assert property (
    @(posedge core_clk) disable iff (!nrst)
    s_addr_err_report |=> serr_oe)
    else $error("SERR# not driven for reported address error");

  a_serr_gate_off: assert property (
    @(posedge core_clk) disable iff (!nrst)
    serr_oe |-> $past(serr_en) && $past(par_resp) && $past(addr_err))
    else $error("SERR# driven without both enables");

  a_b2b_same_only: assert property (
    @(posedge core_clk) disable iff (!nrst)
    b2b_req && !b2b_same_agent && !fast_b2b |=> !b2b_grant)
    else $error("Back-to-back to other agent with enable off");

  a_b2b_other_ok: assert property (
    @(posedge core_clk) disable iff (!nrst)
    b2b_req && fast_b2b |=> b2b_grant)
    else $error("Back-to-back refused with enable on");

  a_resp_reset_zero: assert property (
    @(posedge core_clk) disable iff (!nrst)
    boot |-> !par_resp && !perr_oe)
    else $error("Parity response not zero after reset");

  a_parity_always: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !boot ##1 1 |-> par_out == $past(^{bus.ad, bus.cbe}, 2))
    else $error("Parity output wrong");

  a_palette_snoop: assert property (
    @(posedge core_clk) disable iff (!nrst)
    palette_wr && snoop |=> palette_snoop && !palette_claim)
    else $error("Palette write claimed while snooping");

  a_cfg_only_zero: assert property (
    @(posedge core_clk) disable iff (!nrst)
    cfg_only |-> !mem_decode_en && !io_decode_en && !master_en)
    else $error("Decode active with command cleared");

  a_step_readback: assert property (
    @(posedge core_clk) disable iff (!nrst)
    cfg_rvalid && $past(cfg.rd) && $past(cmd_hit(cfg.addr))
    |-> cfg_rdata[pcmd_pkg::CMD_STEP] ==
        ((STEP_MODE == pcmd_pkg::PCMD_STEP_NEVER) ? 1'b0 :
         (STEP_MODE == pcmd_pkg::PCMD_STEP_ALWAYS) ? 1'b1 :
         $past(cmd[pcmd_pkg::CMD_STEP])))
    else $error("Stepping bit reads wrong value");

endmodule
`default_nettype wire

// *** core/pcmd_pkg.sv ***
`default_nettype none
package pcmd_pkg;

  // Configuration word that holds command (low) and status (high).
  localparam logic [5:0]  CMD_WORD_IDX  = 6'h01;
  localparam logic [7:0]  CMD_OFFSET    = 8'h04;
  localparam logic [15:0] CMD_RESET     = 16'h0000;

  // Command field positions.
  localparam int CMD_IOS    = 0;
  localparam int CMD_MS     = 1;
  localparam int CMD_BM     = 2;
  localparam int CMD_SC     = 3;
  localparam int CMD_MWIE   = 4;
  localparam int CMD_SNOOP  = 5;
  localparam int CMD_PAR_RESP = 6;
  localparam int CMD_STEP     = 7;
  localparam int CMD_SERR_EN  = 8;
  localparam int CMD_FAST_B2B = 9;

  // Status half of the word and its detected parity error flag.
  localparam int STS_BASE     = 16;
  localparam int STS_PAR_ERR  = 15;

  // Bits that are always plain read/write; bits 7 and 5 depend on options.
  localparam logic [15:0] CMD_WMASK_BASE = 16'hff57;
  localparam logic [15:0] STEP_BIT       = 16'h0080;
  localparam logic [15:0] SNOOP_BIT      = 16'h0020;

  // Byte lanes of the configuration word.
  localparam int LANES      = 4;
  localparam int LANE_W     = 8;

  // Stepping capability of the function.
  typedef enum logic [2:0] {
    PCMD_STEP_NEVER    = 3'h1,
    PCMD_STEP_ALWAYS   = 3'h2,
    PCMD_STEP_OPTIONAL = 3'h4
  } pcmd_step_t;

  // One configuration access from the PCI target logic.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pcmd_cfg_req_t;

  // Bus phase information for parity work.
  typedef struct packed {
    logic        addr_phase;
    logic        data_phase;
    logic [31:0] ad;
    logic [3:0]  cbe;
  } pcmd_bus_t;

endpackage
`default_nettype wire

// *** core/pcmd_parity.sv ***
`default_nettype none
// Even parity generator and checker over AD and C/BE#.
module pcmd_parity (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire pcmd_pkg::pcmd_bus_t bus,
  input  wire logic              par_in,
  output logic                   par_gen,
  output logic                   addr_err,
  output logic                   data_err
);

  logic chk_addr;  // Previous cycle was an address phase.
  logic chk_data;  // Previous cycle was a data phase.

  // Parity is produced every cycle, independent of any enable, because
  // PAR lags AD by one clock and the generated value must always be ready.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      par_gen <= 1'b0;
    end else begin
      par_gen <= ^{bus.ad, bus.cbe};
    end
  end

  // Remember which phase the generated parity belongs to.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      chk_addr <= 1'b0;
      chk_data <= 1'b0;
    end else begin
      chk_addr <= bus.addr_phase;
      chk_data <= bus.data_phase;
    end
  end

  // Compare the incoming PAR with the value computed one clock earlier.
  always_comb begin
    addr_err = chk_addr && (par_in != par_gen);
    data_err = chk_data && (par_in != par_gen);
  end

endmodule
`default_nettype wire

// *** core/pcmd_step_note.sv ***
`default_nettype none
`default_nettype wire

// *** tb/pcmd_host_model.sv ***
`default_nettype none
// Configuration software and bus agent on the far side of the command bits.
module pcmd_host_model (
  input  wire logic                  core_clk,
  output var pcmd_pkg::pcmd_cfg_req_t cfg,
  output var pcmd_pkg::pcmd_bus_t     bus,
  output var logic                   par_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Everything starts idle so no request is seen before reset ends.
  initial begin
    cfg    = '0;
    bus    = '0;
    par_in = 1'b0;
  end

  // One configuration write, held for exactly one taking edge.
  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] en, input logic all_fbb);
    logic [31:0] w;
    w = d;
    // Only the command word gets the software conventions applied.
    if (a == pcmd_pkg::CMD_OFFSET) begin
      w[15:10] = 6'h00;
      w[9]     = all_fbb;
    end
    @(posedge core_clk);
    cfg <= '{wr: 1'b1, rd: 1'b0, addr: a, be: en, wdata: w};
    @(posedge core_clk);
    // Released fields drift so a stale value never passes for a live one.
    cfg <= '{wr: 1'b0, rd: 1'b0, addr: ~a, be: 4'h0, wdata: ~w};
  endtask

  // One configuration read; the caller samples the answer just after return.
  task automatic cfg_rd(input logic [7:0] a);
    @(posedge core_clk);
    cfg <= '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hf, wdata: cfg.wdata};
    @(posedge core_clk);
    cfg <= '{wr: 1'b0, rd: 1'b0, addr: ~a, be: 4'h0, wdata: ~cfg.wdata};
  endtask

  // One address or data phase followed by its parity one cycle later.
  task automatic phase(input logic ap, input logic [31:0] ad,
                       input logic [3:0] cbe, input logic bad);
    @(posedge core_clk);
    bus <= '{addr_phase: ap, data_phase: !ap, ad: ad, cbe: cbe};
    @(posedge core_clk);
    // One flipped bit keeps the idle cycle's parity different.
    bus    <= '{addr_phase: 1'b0, data_phase: 1'b0, ad: ad ^ 32'h1, cbe: cbe};
    par_in <= ^{ad, cbe} ^ bad;
    @(posedge core_clk);
    par_in <= ~par_in;
  endtask
endmodule
`default_nettype wire

// *** tb/pcmd_tb_top.sv ***
`default_nettype none
// Random command traffic mixed with parity, arbitration and palette probes.
module pcmd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] WMASK = pcmd_pkg::CMD_WMASK_BASE |
                                  pcmd_pkg::STEP_BIT | pcmd_pkg::SNOOP_BIT;

  logic                    core_clk;
  logic                    nrst;
  pcmd_pkg::pcmd_cfg_req_t cfg;
  pcmd_pkg::pcmd_bus_t     bus;
  logic                    par_in;
  logic [31:0]             cfg_rdata;
  logic                    cfg_rvalid;
  logic                    par_out;
  logic                    b2b_req;
  logic                    b2b_same_agent;
  logic                    b2b_grant;
  logic                    palette_wr;
  logic                    palette_claim;
  logic                    palette_snoop;
  logic                    serr_n_out;
  logic                    serr_oe;
  logic                    perr_n_out;
  logic                    perr_oe;
  logic                    detected_parity_error;
  logic                    stepping_active;
  logic                    mem_decode_en;
  logic                    io_decode_en;
  logic                    master_en;
  logic                    cfg_only;
  logic [15:0]             ecmd;        // Expected command value.
  logic                    edpe;        // Expected sticky parity flag.
  int                      n_fail;      // Mismatches seen.
  int                      comparisons; // Comparisons made.

  pcmd_top #(
    .STEP_MODE (pcmd_pkg::PCMD_STEP_OPTIONAL),
    .SNOOP_IMPL(1'b1)
  ) DUT (
    .core_clk(core_clk), .nrst(nrst), .cfg(cfg),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .bus(bus),
    .par_in(par_in), .par_out(par_out), .b2b_req(b2b_req),
    .b2b_same_agent(b2b_same_agent), .b2b_grant(b2b_grant),
    .palette_wr(palette_wr), .palette_claim(palette_claim),
    .palette_snoop(palette_snoop), .serr_n_out(serr_n_out),
    .serr_oe(serr_oe), .perr_n_out(perr_n_out), .perr_oe(perr_oe),
    .detected_parity_error(detected_parity_error),
    .stepping_active(stepping_active), .mem_decode_en(mem_decode_en),
    .io_decode_en(io_decode_en), .master_en(master_en),
    .cfg_only(cfg_only)
  );

  pcmd_host_model host (
    .core_clk(core_clk), .cfg(cfg), .bus(bus), .par_in(par_in)
  );

  // Free-running clock at 125 MHz.
  always #4 core_clk = ~core_clk;

  // Command value after a write, honouring byte enables and fixed bits.
  function automatic logic [15:0] exp_cmd(input logic [15:0] cur,
      input logic [15:0] w, input logic [3:0] en);
    logic [15:0] m;
    m = WMASK & {{8{en[1]}}, {8{en[0]}}};
    return (cur & ~m) | (w & m);
  endfunction

  // Shared comparison; four-state equality so unknowns never match.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Verdict and end of run, reached from the main flow or the watchdog.
  task automatic summarize;
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog sized well above the forty iterations of the main flow.
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    summarize();
  end

  // Main sequence.
  initial begin
    logic [31:0] d;
    logic [3:0]  en;
    logic        r;
    logic        s;
    logic        p;
    logic        ap;
    logic        bad;
    core_clk       = 1'b0;
    nrst           = 1'b0;
    b2b_req        = 1'b0;
    b2b_same_agent = 1'b0;
    palette_wr     = 1'b0;
    n_fail         = 0;
    comparisons    = 0;
    ecmd           = pcmd_pkg::CMD_RESET | pcmd_pkg::STEP_BIT;
    edpe           = 1'b0;
    d              = $urandom(51799);
    @(posedge core_clk);
    #1;
    chk("cfg_only in reset", 1, cfg_only);
    chk("perr_n_out in reset", 1, perr_n_out);
    repeat (7) @(posedge core_clk);
    nrst <= 1'b1;
    host.cfg_rd(pcmd_pkg::CMD_OFFSET);
    #1;
    chk("cfg_rvalid", 1, cfg_rvalid);
    chk("reset word", {edpe, 15'h0, ecmd}, cfg_rdata);
    for (int i = 0; i < 40; i++) begin
      // First pass writes all zeros: decoding must drop to config only.
      d  = (i == 0) ? 32'h0 : $urandom;
      en = (i == 0) ? 4'h3 : 4'($urandom);
      host.cfg_wr(pcmd_pkg::CMD_OFFSET, d, en, d[9]);
      ecmd = exp_cmd(ecmd, {6'h00, d[9:0]}, en);
      if (en[3] && d[31])
        edpe = 1'b0;
      // Now and then hit an unmapped word, which must stay silent.
      if (i % 8 == 7) begin
        host.cfg_wr(8'h08, $urandom, 4'hf, 1'b1);
        host.cfg_rd(8'h08);
        #1;
        chk("unmapped word", 0, cfg_rdata);
      end
      host.cfg_rd(pcmd_pkg::CMD_OFFSET);
      #1;
      chk("command word", {edpe, 15'h0, ecmd}, cfg_rdata);
      chk("cfg_only", ecmd[2:0] == 3'h0, cfg_only);
      chk("stepping_active", ecmd[7], stepping_active);
      chk("io_decode_en", ecmd[0], io_decode_en);
      chk("mem_decode_en", ecmd[1], mem_decode_en);
      chk("master_en", ecmd[2], master_en);
      {r, s, p} = 3'($urandom);
      @(posedge core_clk);
      b2b_req        <= r;
      b2b_same_agent <= s;
      palette_wr     <= p;
      @(posedge core_clk);
      b2b_req        <= 1'b0;
      b2b_same_agent <= ~s;
      palette_wr     <= 1'b0;
      #1;
      chk("b2b_grant", r & (s | ecmd[9]), b2b_grant);
      chk("palette_claim", p & ecmd[0] & !ecmd[5], palette_claim);
      chk("palette_snoop", p & ecmd[5], palette_snoop);
      ap  = 1'($urandom);
      bad = 1'($urandom);
      d   = $urandom;
      en  = 4'($urandom);
      host.phase(ap, d, en, bad);
      #1;
      edpe = edpe | bad;
      chk("par_out", ^{d, en}, par_out);
      chk("perr_oe", !ap & bad & ecmd[6], perr_oe);
      chk("perr_n_out", !(!ap & bad & ecmd[6]), perr_n_out);
      chk("serr_oe", ap & bad & ecmd[6] & ecmd[8], serr_oe);
      chk("serr_n_out", 0, serr_n_out);
      chk("parity flag", edpe, detected_parity_error);
    end
    summarize();
  end
endmodule
`default_nettype wire
